// File: hdl/lfd_channel.sv
/*
  One receive channel of the link fault detector: line receiver selection,
  amplitude gate, transition density check, range control and the
  registered active-low fault flag. Assumes all inputs are synchronous to
  clk and that tick inputs are one-cycle enables.
*/
`timescale 1ns/100ps
module lfd_channel
  import lfd_pkg::*;
#(
  parameter int RANGE_PERIOD = LFD_RANGE_PERIODS
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 enable,
  input  wire logic                 line_select,
  input  wire logic                 char_valid,
  input  wire logic [CHAR_BITS-1:0] char1,
  input  wire logic [CHAR_BITS-1:0] char2,
  input  wire logic [AMP_W-1:0]     amp1,
  input  wire logic [AMP_W-1:0]     amp2,
  input  wire logic [AMP_W-1:0]     amp_trip,
  input  wire logic                 train_tick,
  input  wire logic                 vco_tick,
  input  wire logic                 rate_high,
  output logic                      fault_n,
  output logic                      osc_force,
  output logic [CHAR_BITS-1:0]      cdr_char
);
  // Expected recovered ticks per interval and allowed error band
  localparam int EXP_L = RANGE_PERIOD;
  localparam int EXP_H = 2 * RANGE_PERIOD;
  localparam int TOL_L = EXP_L * LFD_TOL_PPM / LFD_PPM_SCALE;
  localparam int TOL_H = EXP_H * LFD_TOL_PPM / LFD_PPM_SCALE;
  localparam logic [16:0] MIN_L = 17'(EXP_L - TOL_L);
  localparam logic [16:0] MAX_L = 17'(EXP_L + TOL_L);
  localparam logic [16:0] MIN_H = 17'(EXP_H - TOL_H);
  localparam logic [16:0] MAX_H = 17'(EXP_H + TOL_H);
  localparam logic [16:0] LAST_TRAIN = 17'(RANGE_PERIOD - 1);

  typedef struct packed {
    logic                 last_bit;    // Last bit of previous character
    logic [2:0]           quiet_cnt;   // Characters without transition
    logic [1:0]           good_cnt;    // Adjacent characters with transitions
    logic                 dens_fault;  // Transition density fault
    logic [16:0]          train_cnt;   // Training periods in interval
    logic [16:0]          vco_cnt;     // Recovered ticks in interval
    lfd_rc_state_t        rc_state;    // Range control state
    logic                 range_ok;    // Last measurement in band
    logic                 osc_force;   // Oscillator forced to reference
    logic                 fault_n;     // Registered flag, low is fault
    logic [CHAR_BITS-1:0] cdr_char;    // Character routed to recovery
  } lfd_ch_state_t;

  lfd_ch_state_t st_reg;  // Current state
  lfd_ch_state_t st_next; // Next state

  logic [CHAR_BITS-1:0] sel_char;  // Character of the chosen receiver
  logic [AMP_W-1:0]     sel_amp;   // Amplitude of the chosen receiver
  logic                 has_trans; // Character holds a transition
  logic                 amp_ok;    // Amplitude above trip point
  logic                 in_band;   // Measured rate inside band
  logic [16:0]          vco_meas;  // Interval ticks including this cycle

  // Next state logic
  always_comb begin
    st_next   = st_reg;
    sel_char  = line_select ? char2 : char1;
    sel_amp   = line_select ? amp2 : amp1;
    amp_ok    = sel_amp > amp_trip;
    has_trans = |(sel_char ^ {sel_char[CHAR_BITS-2:0], st_reg.last_bit});
    // Boundary tick belongs to the closing interval, so the first interval
    // after enable or release counts as many ticks as a steady one
    vco_meas  = st_reg.vco_cnt + {16'h0000, vco_tick};
    in_band   = rate_high ? (vco_meas >= MIN_H && vco_meas <= MAX_H)
                          : (vco_meas >= MIN_L && vco_meas <= MAX_L);
    if (!enable) begin
      // Powered down: all monitors restart from scratch
      st_next          = '0;
      st_next.rc_state = LFD_RC_TRACK;
    end else begin
      if (char_valid) begin
        st_next.cdr_char = sel_char;
        st_next.last_bit = sel_char[CHAR_BITS-1];
        if (has_trans) begin
          st_next.quiet_cnt = '0;
        end else if (st_reg.quiet_cnt == LFD_QUIET_LIMIT) begin
          st_next.dens_fault = 1'b1;
        end else begin
          st_next.quiet_cnt = st_reg.quiet_cnt + 3'h1;
        end
        // Recovery needs three adjacent good characters
        if (st_reg.dens_fault) begin
          if (!has_trans) begin
            st_next.good_cnt = '0;
          end else if (st_reg.good_cnt == LFD_GOOD_LAST) begin
            st_next.dens_fault = 1'b0;
            st_next.good_cnt   = '0;
          end else begin
            st_next.good_cnt = st_reg.good_cnt + 2'h1;
          end
        end
      end
      // Count recovered ticks across the interval
      if (vco_tick && !(&st_reg.vco_cnt)) begin
        st_next.vco_cnt = st_reg.vco_cnt + 17'h00001;
      end
      if (train_tick) begin
        if (st_reg.train_cnt == LAST_TRAIN) begin
          // Interval boundary: sample, force or release
          st_next.train_cnt = '0;
          st_next.vco_cnt   = '0;
          case (st_reg.rc_state)
            LFD_RC_TRACK: begin
              st_next.range_ok = in_band;
              if (!in_band) begin
                st_next.rc_state  = LFD_RC_FORCE;
                st_next.osc_force = 1'b1;
              end
            end
            LFD_RC_FORCE: begin
              // Released; lock must show within the next interval
              st_next.rc_state  = LFD_RC_TRACK;
              st_next.osc_force = 1'b0;
              st_next.range_ok  = 1'b0;
            end
            default: begin
              st_next.rc_state = LFD_RC_TRACK;
            end
          endcase
        end else begin
          st_next.train_cnt = st_reg.train_cnt + 17'h00001;
        end
      end
    end
    // All four checks must pass together
    st_next.fault_n = enable
                    & amp_ok & ~st_reg.dens_fault
                    & st_reg.range_ok & ~st_reg.osc_force;
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg          <= '0;
      st_reg.rc_state <= LFD_RC_TRACK;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fault_n   = st_reg.fault_n;
  assign osc_force = st_reg.osc_force;
  assign cdr_char  = st_reg.cdr_char;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence seq_quiet_trip;
    enable && char_valid && !has_trans && st_reg.quiet_cnt == LFD_QUIET_LIMIT;
  endsequence

  chk_force_flag_low: assert property (st_reg.osc_force |=> !fault_n)
    else $error("Flag not low while oscillator forced");
  chk_quiet_trip: assert property (seq_quiet_trip |=> st_reg.dens_fault ##1 !fault_n)
    else $error("Quiet span did not raise fault");
  chk_recover_three: assert property ($fell(st_reg.dens_fault) && $past(enable) |->
      $past(st_reg.good_cnt) == LFD_GOOD_LAST && $past(has_trans))
    else $error("Fault cleared without three good characters");
  chk_amp_gate: assert property (enable && !amp_ok |=> !fault_n)
    else $error("Low amplitude not flagged");
  chk_force_entry: assert property ($rose(st_reg.osc_force) |->
      $past(st_reg.train_cnt) == LAST_TRAIN && !$past(in_band))
    else $error("Force without out of band measurement");
endmodule

// File: hdl/lfd_pkg.sv
/*
  Shared constants and types of the link fault detector: amplitude trip
  points, ternary select codes, transition density limits and range control
  figures. Assumes the ternary pins have been resolved into two-bit codes
  upstream.
*/
package lfd_pkg;
  localparam int NUM_CH    = 4;        // Receive channels A to D
  localparam int CHAR_BITS = 10;       // Bits per received character
  localparam int AMP_W     = 10;       // Amplitude estimate in mV

  // Ternary select codes; the fourth code is treated like an open pin
  localparam logic [1:0] LFD_TRI_LOW  = 2'h0;
  localparam logic [1:0] LFD_TRI_MID  = 2'h1;
  localparam logic [1:0] LFD_TRI_HIGH = 2'h2;

  // Amplitude trip points, mV peak-to-peak differential
  localparam logic [AMP_W-1:0] LFD_TRIP_LOW_MV  = 10'h08C;  // 140 mV
  localparam logic [AMP_W-1:0] LFD_TRIP_MID_MV  = 10'h118;  // 280 mV
  localparam logic [AMP_W-1:0] LFD_TRIP_HIGH_MV = 10'h1A4;  // 420 mV

  // Transition density: six quiet characters allowed, three good to clear
  localparam logic [2:0] LFD_QUIET_LIMIT = 3'h6;
  localparam logic [1:0] LFD_GOOD_LAST   = 2'h2;  // Third good character index

  // Range control figures
  localparam int LFD_RANGE_PERIODS = 16000;  // Training clock periods
  localparam int LFD_TOL_PPM       = 1500;
  localparam int LFD_PPM_SCALE     = 1000000;
  localparam logic [4:0] LFD_MULT_LOW  = 5'h0A;  // Forced multiple x10
  localparam logic [4:0] LFD_MULT_HIGH = 5'h14;  // Forced multiple x20

  // Range control states
  typedef enum logic {LFD_RC_TRACK, LFD_RC_FORCE} lfd_rc_state_t;
endpackage

// File: hdl/lfd_top.sv
/*
  Four channel link fault detector top: channel enable and self-test enable
  latches, amplitude trip selection, reference character tick multiplier,
  speed range decode and the per-channel monitors. Assumes every input is
  synchronous to CLK and tick inputs are one-cycle enables of CLK.
*/
//
// Summary of operation
// - Flag valid only when all four checks pass
// - Threshold select picks 140, 280, 420 mV
// - One threshold setting shared by all channels
// - Amplitude checked on the selected receiver only
// - Over six quiet characters raises the fault
// - Three adjacent good characters clear density fault
// - Out-of-band oscillator forced then released to relock
// - Sampling interval is 16000 training periods
// - Flag low while the oscillator is forced
// - Lock shows within one interval of valid input
// - Enable latch transparent on strobe, holds otherwise
// - Enable bit 3..0 map to channels D..A
// - One enables a channel, zero powers down
// - Disabled channel shows the fault level
// - Self-test latch takes the same enable bits
// - Speed select picks one of three rate ranges
// - Training clock at one tenth or twentieth rate
// - Multiplier makes character ticks for every channel
// - Line select routes one receiver to recovery
//
`timescale 1ns/100ps
module lfd_top
  import lfd_pkg::*;
#(
  parameter int RANGE_PERIOD = LFD_RANGE_PERIODS,  // Training periods per interval
  parameter int TICK_CNT_W   = 8                   // Width of the tick spacing counter
) (
  input  wire logic                          CLK,
  input  wire logic                          NRST,
  input  wire logic [NUM_CH-1:0]             CHANNEL_BIT_ENABLES,
  input  wire logic                          RX_ENABLE_LATCH_STROBE,
  input  wire logic                          SELFTEST_LATCH_STROBE,
  input  wire logic [1:0]                    AMPLITUDE_THRESHOLD_SELECT,
  input  wire logic [1:0]                    SPEED_RANGE_SELECT,
  input  wire logic                          TRAINING_RATE_SELECT,
  input  wire logic                          TRAINING_CLOCK_TICK,
  input  wire logic [NUM_CH-1:0]             LINE_INPUT_SELECT,
  input  wire logic [NUM_CH-1:0]             CHAR_VALID,
  input  wire logic [NUM_CH*CHAR_BITS-1:0]   LINE1_CHAR,
  input  wire logic [NUM_CH*CHAR_BITS-1:0]   LINE2_CHAR,
  input  wire logic [NUM_CH*AMP_W-1:0]       LINE1_AMPLITUDE,
  input  wire logic [NUM_CH*AMP_W-1:0]       LINE2_AMPLITUDE,
  input  wire logic [NUM_CH-1:0]             RECOVERED_CHAR_TICK,
  output logic      [NUM_CH-1:0]             LINK_FAULT_FLAG_N,
  output logic      [NUM_CH-1:0]             OSC_FORCE,
  output logic      [NUM_CH*CHAR_BITS-1:0]   CDR_CHAR,
  output logic      [NUM_CH-1:0]             CHANNEL_ENABLE,
  output logic      [NUM_CH-1:0]             SELFTEST_ENABLE,
  output logic      [4:0]                    FORCE_MULTIPLE,
  output logic                               CHAR_RATE_TICK,
  output logic      [1:0]                    SPEED_RANGE,
  output logic                               RESERVED_CONFIG
);

  // Whole top-level state in one record
  typedef struct packed {
    logic [NUM_CH-1:0]     rx_en;       // Receive channel enable latch
    logic [NUM_CH-1:0]     st_en;       // Self-test channel enable latch
    logic [AMP_W-1:0]      amp_trip;    // Shared amplitude trip point
    logic [1:0]            speed;       // Decoded speed range
    logic                  reserved;    // Unsupported select combination
    logic [4:0]            mult;        // Forced oscillator multiple
    logic [TICK_CNT_W-1:0] period_cnt;  // Cycles since last training tick
    logic [TICK_CNT_W-1:0] half_pt;     // Half of the last training period
    logic                  char_tick;   // Reference character tick
    logic                  rate_high;   // Registered training rate select
  } lfd_top_state_t;

  lfd_top_state_t st_reg;  // Current state
  lfd_top_state_t st_next; // Next state

  // Top-level next state logic
  always_comb begin
    st_next = st_reg;

    // Latches follow the bits while the strobe is high
    if (RX_ENABLE_LATCH_STROBE) begin
      st_next.rx_en = CHANNEL_BIT_ENABLES;
    end
    if (SELFTEST_LATCH_STROBE) begin
      st_next.st_en = CHANNEL_BIT_ENABLES;
    end

    // One trip point for every channel
    case (AMPLITUDE_THRESHOLD_SELECT)
      LFD_TRI_LOW:  st_next.amp_trip = LFD_TRIP_LOW_MV;
      LFD_TRI_HIGH: st_next.amp_trip = LFD_TRIP_HIGH_MV;
      default:      st_next.amp_trip = LFD_TRIP_MID_MV;
    endcase

    // Speed range: open pin code counts as middle
    case (SPEED_RANGE_SELECT)
      LFD_TRI_LOW:  st_next.speed = LFD_TRI_LOW;
      LFD_TRI_HIGH: st_next.speed = LFD_TRI_HIGH;
      default:      st_next.speed = LFD_TRI_MID;
    endcase
    // Flag only; the rest of the logic is not altered by it
    st_next.reserved = (SPEED_RANGE_SELECT == LFD_TRI_LOW) && TRAINING_RATE_SELECT;

    // Forced multiple follows the training ratio
    st_next.rate_high = TRAINING_RATE_SELECT;
    st_next.mult      = TRAINING_RATE_SELECT ? LFD_MULT_HIGH : LFD_MULT_LOW;

    // Character tick multiplier: a training tick gives one character tick,
    // at the half rate a second one midway through the measured period
    if (TRAINING_CLOCK_TICK) begin
      st_next.period_cnt = '0;
      st_next.half_pt    = st_reg.period_cnt >> 1;
      st_next.char_tick  = 1'b1;
    end else begin
      if (!(&st_reg.period_cnt)) begin
        st_next.period_cnt = st_reg.period_cnt + TICK_CNT_W'(1);
      end
      // Midpoint tick only when a period has actually been measured
      st_next.char_tick = st_reg.rate_high && (st_reg.half_pt != '0)
                        && (st_reg.period_cnt == st_reg.half_pt);
    end
  end

  // Top-level state register
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st_reg          <= '0;
      st_reg.amp_trip <= LFD_TRIP_MID_MV;
      st_reg.speed    <= LFD_TRI_MID;
      st_reg.mult     <= LFD_MULT_LOW;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state flops
  assign CHANNEL_ENABLE  = st_reg.rx_en;
  assign SELFTEST_ENABLE = st_reg.st_en;
  assign SPEED_RANGE     = st_reg.speed;
  assign RESERVED_CONFIG = st_reg.reserved;
  assign FORCE_MULTIPLE  = st_reg.mult;
  assign CHAR_RATE_TICK  = st_reg.char_tick;

  // Independent monitor per channel; bit i is channel A+i
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      lfd_channel #(
        .RANGE_PERIOD (RANGE_PERIOD)
      ) u_ch (
        .clk         (CLK),
        .nrst        (NRST),
        .enable      (st_reg.rx_en[gi]),
        .line_select (LINE_INPUT_SELECT[gi]),
        .char_valid  (CHAR_VALID[gi]),
        .char1       (LINE1_CHAR[gi*CHAR_BITS +: CHAR_BITS]),
        .char2       (LINE2_CHAR[gi*CHAR_BITS +: CHAR_BITS]),
        .amp1        (LINE1_AMPLITUDE[gi*AMP_W +: AMP_W]),
        .amp2        (LINE2_AMPLITUDE[gi*AMP_W +: AMP_W]),
        .amp_trip    (st_reg.amp_trip),
        .train_tick  (TRAINING_CLOCK_TICK),
        .vco_tick    (RECOVERED_CHAR_TICK[gi]),
        .rate_high   (st_reg.rate_high),
        .fault_n     (LINK_FAULT_FLAG_N[gi]),
        .osc_force   (OSC_FORCE[gi]),
        .cdr_char    (CDR_CHAR[gi*CHAR_BITS +: CHAR_BITS])
      );
    end
  endgenerate

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence seq_latch_close;
    RX_ENABLE_LATCH_STROBE ##1 !RX_ENABLE_LATCH_STROBE;
  endsequence

  chk_latch_follow: assert property (RX_ENABLE_LATCH_STROBE |=>
      CHANNEL_ENABLE == $past(CHANNEL_BIT_ENABLES))
    else $error("Enable latch not transparent");
  chk_latch_hold: assert property (seq_latch_close |=>
      CHANNEL_ENABLE == $past(CHANNEL_BIT_ENABLES, 2))
    else $error("Enable latch lost captured value");
  chk_selftest_latch: assert property (!SELFTEST_LATCH_STROBE |=> $stable(SELFTEST_ENABLE))
    else $error("Self-test latch changed while closed");
  chk_disabled_fault: assert property (CHANNEL_ENABLE == '0 |=> LINK_FAULT_FLAG_N == '0)
    else $error("Disabled channels not flagged");
  chk_trip_low: assert property (AMPLITUDE_THRESHOLD_SELECT == LFD_TRI_LOW |=>
      st_reg.amp_trip == LFD_TRIP_LOW_MV)
    else $error("Low trip point not selected");
  chk_mult_select: assert property (TRAINING_RATE_SELECT |=> FORCE_MULTIPLE == LFD_MULT_HIGH)
    else $error("Forced multiple wrong for half rate");
  chk_reserved_cfg: assert property (SPEED_RANGE_SELECT == LFD_TRI_LOW
      && TRAINING_RATE_SELECT |=> RESERVED_CONFIG)
    else $error("Reserved combination not reported");
endmodule

// File: sim/lfd_remote_tx.sv
/*
  Far-side model: remote transmitter plus the local training reference.
  Makes training ticks, character strobes, recovered clock ticks and line data.
  Assumes the bench drives quiet and stall by non-blocking assignment.
*/
`timescale 1ns/100ps
module lfd_remote_tx
  import lfd_pkg::*;
#(
  parameter int TICK_PERIOD = 4  // Clock cycles per training period
) (
  input  wire logic                        clk,
  input  wire logic [NUM_CH-1:0]           quiet,
  input  wire logic [NUM_CH-1:0]           stall,
  output logic                             train_tick,
  output logic      [NUM_CH-1:0]           char_valid,
  output logic      [NUM_CH-1:0]           rec_tick,
  output logic      [NUM_CH*CHAR_BITS-1:0] line1_char,
  output logic      [NUM_CH*CHAR_BITS-1:0] line2_char
);
  int                   phase = 0;  // Position within a training period
  logic [CHAR_BITS-1:0] v1;         // Line 1 character of this period
  logic [CHAR_BITS-1:0] v2;         // Line 2 character of this period

  // Quiet start so no input is unknown at time zero
  initial begin
    train_tick = 1'b0;
    char_valid = '0;
    rec_tick   = '0;
    line1_char = '0;
    line2_char = '0;
  end

  // Launch on the falling edge, well away from the sampling edge
  always @(negedge clk) begin
    phase = (phase + 1) % TICK_PERIOD;
    train_tick <= (phase == 0);
    for (int i = 0; i < NUM_CH; i++) begin
      v1 = quiet[i] ? 10'h000 : 10'h155;
      v2 = quiet[i] ? 10'h000 : 10'h2AA;
      char_valid[i] <= (phase == 0);
      rec_tick[i]   <= (phase == 0) && !stall[i];
      // Outside the strobe the lines show the inverse, never a held value
      line1_char[i*CHAR_BITS +: CHAR_BITS] <= (phase == 0) ? v1 : ~v1;
      line2_char[i*CHAR_BITS +: CHAR_BITS] <= (phase == 0) ? v2 : ~v2;
    end
  end
endmodule

// File: sim/tb_top.sv
/*
  Self-checking bench of the four channel link fault detector.
  Assumes a short range interval (RP training periods of TP cycles each).
*/
`timescale 1ns/100ps
module tb_top
  import lfd_pkg::*;
;
  localparam int RP = 20;  // Shortened range interval
  localparam int TP = 4;   // Cycles per training period

  logic clk = 1'b0, nrst = 1'b0, rx_le = 1'b0, st_le = 1'b0, rate_sel = 1'b0;
  logic [3:0] bits = '0, line_sel = '0, quiet = '0, stall = '0;
  logic [1:0] amp_sel = 2'h1, spd_sel = 2'h1;
  logic [AMP_W-1:0] amp1 = 10'h12C, amp2 = 10'h000;  // 300 mV and silence
  logic tt, crt, rsv;
  logic [3:0] cv, rt, flag_n, force_o, ch_en, st_en;
  logic [39:0] l1, l2, cdr;
  logic [4:0] fmul;
  logic [1:0] srange;
  int num_errors = 0, comparisons = 0, cnt;
  logic [1:0] tsel[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h1};
  logic [9:0] tamp[6] = '{10'h12C, 10'h12C, 10'h12C, 10'h12C, 10'h118, 10'h119};
  logic [3:0] texp[6] = '{4'hF, 4'hF, 4'h0, 4'hF, 4'h0, 4'hF};

  // Free-running 25 MHz clock
  always #20 clk = ~clk;

  lfd_remote_tx #(.TICK_PERIOD(TP)) u_lfd_remote_tx (.clk(clk), .quiet(quiet),
    .stall(stall), .train_tick(tt), .char_valid(cv), .rec_tick(rt),
    .line1_char(l1), .line2_char(l2));

  lfd_top #(.RANGE_PERIOD(RP), .TICK_CNT_W(8)) u_lfd_top (.CLK(clk), .NRST(nrst),
    .CHANNEL_BIT_ENABLES(bits), .RX_ENABLE_LATCH_STROBE(rx_le),
    .SELFTEST_LATCH_STROBE(st_le), .AMPLITUDE_THRESHOLD_SELECT(amp_sel),
    .SPEED_RANGE_SELECT(spd_sel), .TRAINING_RATE_SELECT(rate_sel),
    .TRAINING_CLOCK_TICK(tt), .LINE_INPUT_SELECT(line_sel), .CHAR_VALID(cv),
    .LINE1_CHAR(l1), .LINE2_CHAR(l2), .LINE1_AMPLITUDE({4{amp1}}),
    .LINE2_AMPLITUDE({4{amp2}}), .RECOVERED_CHAR_TICK(rt),
    .LINK_FAULT_FLAG_N(flag_n), .OSC_FORCE(force_o), .CDR_CHAR(cdr),
    .CHANNEL_ENABLE(ch_en), .SELFTEST_ENABLE(st_en), .FORCE_MULTIPLE(fmul),
    .CHAR_RATE_TICK(crt), .SPEED_RANGE(srange), .RESERVED_CONFIG(rsv));

  // Per-channel vector comparison
  task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Scalar value comparison
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Advance n falling edges
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Open a latch for one edge, then offer inverted bits that must be ignored
  task automatic set_latch(input logic rx, input logic st, input logic [3:0] b);
    rx_le = rx;
    st_le = st;
    bits = b;
    step(1);
    rx_le = 1'b0;
    st_le = 1'b0;
    bits = ~b;
    step(2);
  endtask

  // Bounded wait for a flag pattern, then compare
  task automatic wait_flags(input logic [3:0] exp, input int lim);
    for (int i = 0; i < lim && flag_n !== exp; i++) step(1);
    chk_vec(flag_n, exp);
  endtask

  // Count strobed characters on channel B, ending at a rising edge
  task automatic wait_chars(input int n);
    repeat (n) begin
      @(posedge clk);
      while (cv[1] !== 1'b1) @(posedge clk);
    end
  endtask

  // Count reference character ticks over ten training periods
  task automatic count_ticks(output int c);
    c = 0;
    repeat (10 * TP) begin
      @(negedge clk);
      if (crt === 1'b1) c++;
    end
  endtask

  // Print counts and verdict, then stop
  task automatic tally_and_finish();
    $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    step(6);
    chk_vec(flag_n, 4'h0);
    chk_vec(ch_en | st_en | force_o, 4'h0);
    chk_val(16'(fmul), 16'h000A);
    chk_val(16'({rsv, srange}), 16'h0001);
    nrst = 1'b1;
    set_latch(1'b1, 1'b0, 4'h5);
    chk_vec(ch_en, 4'h5);
    chk_vec(st_en, 4'h0);
    set_latch(1'b0, 1'b1, 4'hC);
    chk_vec(st_en, 4'hC);
    chk_vec(ch_en, 4'h5);
    chk_vec(flag_n & 4'hA, 4'h0);
    set_latch(1'b1, 1'b0, 4'hF);
    wait_flags(4'hF, 3 * RP * TP);
    // Shared threshold: every channel follows one select
    for (int i = 0; i < 6; i++) begin
      amp_sel = tsel[i];
      amp1 = tamp[i];
      step(3);
      chk_vec(flag_n, texp[i]);
    end
    amp_sel = 2'h1;
    // Channel A moves to its silent second receiver
    line_sel = 4'h1;
    step(3);
    chk_vec(flag_n, 4'hE);
    wait_chars(1);
    step(2);
    chk_val(16'(cdr[9:0]), 16'h02AA);
    chk_val(16'(cdr[19:10]), 16'h0155);
    amp2 = 10'h12C;
    step(3);
    chk_vec(flag_n, 4'hF);
    line_sel = 4'h0;
    // Channel B goes quiet: six characters tolerated, the seventh is not
    wait_chars(1);
    step(1);
    quiet <= 4'h2;
    wait_chars(6);
    step(3);
    chk_vec(flag_n, 4'hF);
    wait_chars(1);
    step(3);
    chk_vec(flag_n, 4'hD);
    quiet <= 4'h0;
    wait_chars(2);
    step(3);
    chk_vec(flag_n, 4'hD);
    wait_chars(1);
    step(3);
    chk_vec(flag_n, 4'hF);
    // Channel C loses its recovered clock
    stall <= 4'h4;
    for (int i = 0; i < 3 * RP * TP && force_o[2] !== 1'b1; i++) step(1);
    step(1);
    chk_vec(flag_n, 4'hB);
    cnt = 1;
    while (force_o[2] === 1'b1 && cnt < 300) begin
      step(1);
      cnt++;
    end
    chk_val(16'(cnt), 16'(RP * TP));
    stall <= 4'h0;
    wait_flags(4'hF, RP * TP + 8);
    // Channel D disabled, others untouched
    set_latch(1'b1, 1'b0, 4'h7);
    chk_vec(ch_en, 4'h7);
    chk_vec(flag_n, 4'h7);
    // Reference character ticks at both training ratios
    count_ticks(cnt);
    chk_val(16'(cnt), 16'h000A);
    rate_sel = 1'b1;
    step(3 * TP);
    count_ticks(cnt);
    chk_val(16'(cnt), 16'h0014);
    chk_val(16'(fmul), 16'h0014);
    for (int i = 0; i < 4; i++) begin
      spd_sel = 2'(i);
      step(2);
      chk_val(16'(srange), (i == 2) ? 16'h0002 : 16'(i != 0));
      chk_val(16'(rsv), 16'(i == 0));
    end
    tally_and_finish();
  end
endmodule
